// ==== hw/arpwm_defs.vh ====
// Purpose: Offsets, field positions, reset values and timing for the autoreload PWM timer.
// Assumes: AXI4-Lite slave, 32-bit data, each 8-bit register in the low byte of one word.
// Notes:   Included by arpwm_top.v and by the checker and the test.
//
// What this block does
// - Capture flag set on capture, cleared by reading either capture byte; writes ignored.
// - Capture interrupt enable gates the capture interrupt request.
// - Counter source: 00 off, 01 lite timebase, 10 CPU clock, 11 fast input.
// - Overflow flag set at FFFh-to-reload, cleared by reading timer control status.
// - Overflow interrupt enable gates the overflow interrupt request.
// - Compare interrupt enable masks interrupts from any channel compare flag.
// - Read-only 12-bit counter increments on each selected clock tick.
// - On overflow counter reloads from the 12-bit reload value.
// - Output enable 1 gives PWM on the pin; 0 releases it to I/O.
// - One-shot enable, channel 3 register only, turns on the one_shot_trigger pulse for counter two.
// - One-shot edge selects capture input edge, effective only while one-shot enabled.
// - Channel polarity 1 inverts the PWM signal.
// - Channel compare flag set when counter equals duty, cleared by reading its register.
// - Break one source: 0 pin, 1 comparator 1.
// - Break one level: 0 low active, 1 high active.
// - Break one active set by hardware on active level; software read/write.
// - Break one pin enable allows the pin to act.
// - During break, enabled channels are forced to their break pattern bit.
// - Break two works like break one with its own bits.
// - Counter two switch picks break flag for channels 2, 3 when counter two drives.
// - Counter one switch picks break flag for channels 0, 1 and otherwise 2, 3.
// - Counter two select: channels 2, 3 from counter one (0) or two (1).
// - Per-counter break enables allow break control; both reset to one.
`ifndef ARPWM_DEFS_VH
`define ARPWM_DEFS_VH

// ***************************************************************
// Register byte addresses
// ***************************************************************
`define ARPWM_TCSR      8'h00
`define ARPWM_CNT_HI    8'h04
`define ARPWM_CNT_LO    8'h08
`define ARPWM_RLD_HI    8'h0c
`define ARPWM_RLD_LO    8'h10
`define ARPWM_OEN       8'h14
`define ARPWM_CCS0      8'h18
`define ARPWM_BRK1      8'h28
`define ARPWM_BRK2      8'h2c
`define ARPWM_DUTY_HI0  8'h30
`define ARPWM_DUTY_LO0  8'h40
`define ARPWM_BRKEN     8'h50
`define ARPWM_CAP_HI    8'h54
`define ARPWM_CAP_LO    8'h58
`define ARPWM_CNT2SEL   8'h5c

// ***************************************************************
// Field positions and reset values
// ***************************************************************
`define ARPWM_TCSR_CAPF   6
`define ARPWM_TCSR_CAPIE  5
`define ARPWM_TCSR_SRC_HI 4
`define ARPWM_TCSR_SRC_LO 3
`define ARPWM_TCSR_OVF    2
`define ARPWM_TCSR_OVFIE  1
`define ARPWM_TCSR_COMPARE_IRQ_ENABLE  0
`define ARPWM_CCS_OSEN    3
`define ARPWM_CCS_OSEDGE  2
`define ARPWM_CCS_POL     1
`define ARPWM_CCS_CMPF    0
`define ARPWM_BRK_SEL     7
`define ARPWM_BRK_LVL     6
`define ARPWM_BRK_ACT     5
`define ARPWM_BRK_PEN     4
`define ARPWM_BRKEN_RST   2'h3
`define ARPWM_MAX_COUNT   12'hfff
`define ARPWM_SRC_OFF     2'h0
`define ARPWM_SRC_LITE    2'h1
`define ARPWM_SRC_CPU     2'h2
`define ARPWM_SRC_FAST    2'h3
`define ARPWM_FAST_MHZ    32
`define ARPWM_RESP_OKAY   2'h0
`define ARPWM_RESP_SLVERR 2'h2

`endif

// ==== hw/arpwm_top.v ====
// Purpose: Counter, compare, PWM outputs and break control of a 12-bit autoreload timer.
// Assumes: Tick inputs are one-cycle pulses synchronous to aclk; the CPU tick is every cycle.
// Notes:   Duty values load directly (no preload); counter two only selects routing here.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "arpwm_defs.vh"

module arpwm_top #(
   parameter NCH = 4
) (
   input  wire        aclk,          // System clock, 200 MHz.
   input  wire        aresetn,       // Synchronous reset, active low.
   input  wire [7:0]  s_axi_awaddr,  // Write address.
   input  wire        s_axi_awvalid, // Write address valid.
   output wire        s_axi_awready, // Write address ready.
   input  wire [31:0] s_axi_wdata,   // Write data.
   input  wire [3:0]  s_axi_wstrb,   // Write strobes.
   input  wire        s_axi_wvalid,  // Write data valid.
   output wire        s_axi_wready,  // Write data ready.
   output reg  [1:0]  s_axi_bresp,   // Write response.
   output reg         s_axi_bvalid,  // Write response valid.
   input  wire        s_axi_bready,  // Write response ready.
   input  wire [7:0]  s_axi_araddr,  // Read address.
   input  wire        s_axi_arvalid, // Read address valid.
   output wire        s_axi_arready, // Read address ready.
   output reg  [31:0] s_axi_rdata,   // Read data.
   output reg  [1:0]  s_axi_rresp,   // Read response.
   output reg         s_axi_rvalid,  // Read data valid.
   input  wire        s_axi_rready,  // Read data ready.
   input  wire        lite_tick,     // Lite timer timebase tick.
   input  wire        fast_tick,     // Tick from the fast input clock.
   input  wire        capture_event, // Input capture strobe.
   input  wire        lite_timer_capture_input, // Capture pin level for one-shot trigger.
   input  wire        break_one_input, // Break one pin.
   input  wire        break_two_input, // Break two pin.
   input  wire        comp_one_out,  // Comparator 1 output.
   input  wire        comp_two_out,  // Comparator 2 output.
   output reg  [3:0]  pwm_out,       // PWM pin levels.
   output reg  [3:0]  pwm_pin_en,    // High while the pin is in PWM mode.
   output reg         one_shot_trigger, // Selected-edge pulse for counter two.
   output reg         overflow_irq,  // Overflow interrupt request.
   output reg         capture_irq,   // Capture interrupt request.
   output reg         compare_irq    // Compare interrupt request.
);

   // ***************************************************************
   // Register state
   // ***************************************************************
   reg [11:0] counter_one_value;
   reg [11:0] counter_one_reload;
   reg [11:0] capture_result;
   reg [11:0] channel_duty_value [0:NCH-1];
   reg [NCH-1:0] channel_polarity;
   reg [NCH-1:0] cmp_flag;
   reg [NCH-1:0] pwm_level;
   reg [7:0]  pwm_output_enables;
   reg        capture_flag;
   reg        capture_irq_enable;
   reg [1:0]  counter_source_select;
   reg        counter_one_overflow_flag;
   reg        counter_one_overflow_irq_en;
   reg        compare_irq_enable;
   reg        one_shot_enable;
   reg        one_shot_trigger_edge;
   reg [7:0]  break_one_control;
   reg [7:0]  break_two_control;
   reg [1:0]  break_enables;
   reg        counter_two_select;
   reg        cap_pin_q;

   reg        aw_held;
   reg        w_held;
   reg [7:0]  aw_addr;
   reg [31:0] w_data;
   reg [3:0]  w_strb;

   integer    i;

   function [7:0] hi_byte;
      input [11:0] v;
      begin
         hi_byte = {4'h0, v[11:8]};
      end
   endfunction

   // Per-channel registers sit one word apart from their group's base.
   function [7:0] ch_off;
      input [7:0]  base;
      input [31:0] n;
      begin
         ch_off = base + {n[5:0], 2'b00};
      end
   endfunction

   // ***************************************************************
   // AXI4-Lite handshakes
   // ***************************************************************
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire       wr_fire = aw_held && w_held;
   wire       rd_fire = s_axi_arvalid && !s_axi_rvalid;
   wire [7:0] rd_a    = s_axi_araddr;
   wire       wl      = w_strb[0];
   wire [7:0] wd      = w_data[7:0];

   wire rd_tcsr = rd_fire && rd_a == `ARPWM_TCSR;
   wire rd_cap  = rd_fire && (rd_a == `ARPWM_CAP_HI || rd_a == `ARPWM_CAP_LO);

   function wr_hit;
      input [7:0] a;
      begin
         wr_hit = wr_fire && wl && aw_addr == a;
      end
   endfunction

   // ***************************************************************
   // Counter and tick selection
   // ***************************************************************
   reg tick;
   always @* begin
      case (counter_source_select)
         `ARPWM_SRC_LITE: tick = lite_tick;
         `ARPWM_SRC_CPU:  tick = 1'b1;
         `ARPWM_SRC_FAST: tick = fast_tick;
         default:         tick = 1'b0;
      endcase
   end

   wire overflow = tick && counter_one_value == `ARPWM_MAX_COUNT;

   // ***************************************************************
   // Break sources
   // ***************************************************************
   wire brk1_sig = break_one_control[`ARPWM_BRK_SEL] ? comp_one_out : break_one_input;
   wire brk2_sig = break_two_control[`ARPWM_BRK_SEL] ? comp_two_out : break_two_input;
   wire brk1_hit = break_one_control[`ARPWM_BRK_PEN] &&
                   (brk1_sig == break_one_control[`ARPWM_BRK_LVL]);
   wire brk2_hit = break_two_control[`ARPWM_BRK_PEN] &&
                   (brk2_sig == break_two_control[`ARPWM_BRK_LVL]);
   wire ba1 = break_one_control[`ARPWM_BRK_ACT];
   wire ba2 = break_two_control[`ARPWM_BRK_ACT];
   wire brk_c1 = break_enables[0] && (break_two_control[0] ? ba2 : ba1);
   wire brk_c2 = break_enables[1] && (break_two_control[1] ? ba2 : ba1);
   wire brk_lo = brk_c1;
   wire brk_hi = counter_two_select ? brk_c2 : brk_c1;
   wire [3:0] oe4 = {pwm_output_enables[6], pwm_output_enables[4],
                     pwm_output_enables[2], pwm_output_enables[0]};

   // ***************************************************************
   // Main clocked process
   // ***************************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ARPWM_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `ARPWM_RESP_OKAY;
         s_axi_rdata <= 32'h0;
         counter_one_value <= 12'h000;
         counter_one_reload <= 12'h000;
         capture_result <= 12'h000;
         for (i = 0; i < NCH; i = i + 1) begin
            channel_duty_value[i] <= 12'h000;
         end
         channel_polarity <= {NCH{1'b0}};
         cmp_flag <= {NCH{1'b0}};
         pwm_level <= {NCH{1'b0}};
         pwm_output_enables <= 8'h00;
         capture_flag <= 1'b0;
         capture_irq_enable <= 1'b0;
         counter_source_select <= `ARPWM_SRC_OFF;
         counter_one_overflow_flag <= 1'b0;
         counter_one_overflow_irq_en <= 1'b0;
         compare_irq_enable <= 1'b0;
         one_shot_enable <= 1'b0;
         one_shot_trigger_edge <= 1'b0;
         break_one_control <= 8'h00;
         break_two_control <= 8'h00;
         break_enables <= `ARPWM_BRKEN_RST;
         counter_two_select <= 1'b0;
         cap_pin_q <= 1'b0;
         one_shot_trigger <= 1'b0;
      end else begin
         // Write channel capture; the response waits for both halves.
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `ARPWM_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end

         // Register writes; low byte lane only.
         if (wr_hit(`ARPWM_TCSR)) begin
            capture_irq_enable <= wd[`ARPWM_TCSR_CAPIE];
            counter_source_select <= wd[`ARPWM_TCSR_SRC_HI:`ARPWM_TCSR_SRC_LO];
            counter_one_overflow_irq_en <= wd[`ARPWM_TCSR_OVFIE];
            compare_irq_enable <= wd[`ARPWM_TCSR_COMPARE_IRQ_ENABLE];
         end
         if (wr_hit(`ARPWM_RLD_HI)) counter_one_reload[11:8] <= wd[3:0];
         if (wr_hit(`ARPWM_RLD_LO)) counter_one_reload[7:0] <= wd;
         if (wr_hit(`ARPWM_OEN)) pwm_output_enables <= wd & 8'h55;
         if (wr_hit(`ARPWM_CNT2SEL)) counter_two_select <= wd[0];
         if (wr_hit(`ARPWM_BRKEN)) break_enables <= wd[1:0];
         if (wr_hit(`ARPWM_CCS0 + 8'h0c)) begin
            one_shot_enable <= wd[`ARPWM_CCS_OSEN];
            one_shot_trigger_edge <= wd[`ARPWM_CCS_OSEDGE];
         end
         for (i = 0; i < NCH; i = i + 1) begin
            if (wr_hit(ch_off(`ARPWM_CCS0, i)))
               channel_polarity[i] <= wd[`ARPWM_CCS_POL];
            if (wr_hit(ch_off(`ARPWM_DUTY_HI0, i)))
               channel_duty_value[i][11:8] <= wd[3:0];
            if (wr_hit(ch_off(`ARPWM_DUTY_LO0, i)))
               channel_duty_value[i][7:0] <= wd;
         end

         // Break registers; hardware set of the active bit wins over a software clear.
         if (wr_hit(`ARPWM_BRK1)) break_one_control <= wd;
         if (wr_hit(`ARPWM_BRK2)) break_two_control <= wd & 8'hf3;
         if (brk1_hit) break_one_control[`ARPWM_BRK_ACT] <= 1'b1;
         if (brk2_hit) break_two_control[`ARPWM_BRK_ACT] <= 1'b1;

         // Counter with autoreload.
         if (overflow) counter_one_value <= counter_one_reload;
         else if (tick) counter_one_value <= counter_one_value + 12'h001;

         // Flags: for overflow and compare flags, a hardware set in the same cycle as a read clear wins.
         if (rd_tcsr) counter_one_overflow_flag <= 1'b0;
         if (overflow) counter_one_overflow_flag <= 1'b1;
         if (rd_cap) capture_flag <= 1'b0;
         if (capture_event && !capture_flag) begin
            capture_flag <= 1'b1;
            capture_result <= counter_one_value;
         end
         for (i = 0; i < NCH; i = i + 1) begin
            if (rd_fire && rd_a == ch_off(`ARPWM_CCS0, i)) cmp_flag[i] <= 1'b0;
            if (tick && counter_one_value == channel_duty_value[i])
               cmp_flag[i] <= 1'b1;
            // PWM is high from reload until the duty match.
            if (overflow) pwm_level[i] <= 1'b1;
            else if (tick && counter_one_value == channel_duty_value[i])
               pwm_level[i] <= 1'b0;
         end

         // One-shot edge detect on the capture pin.
         cap_pin_q <= lite_timer_capture_input;
         one_shot_trigger <= one_shot_enable &&
            (one_shot_trigger_edge ? (lite_timer_capture_input && !cap_pin_q)
                                   : (!lite_timer_capture_input && cap_pin_q));

         // Read channel.
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ARPWM_RESP_OKAY;
            s_axi_rdata <= 32'h0;
            case (rd_a)
               `ARPWM_TCSR: s_axi_rdata[7:0] <= {1'b0, capture_flag, capture_irq_enable,
                  counter_source_select, counter_one_overflow_flag,
                  counter_one_overflow_irq_en, compare_irq_enable};
               `ARPWM_CNT_HI: s_axi_rdata[7:0] <= hi_byte(counter_one_value);
               `ARPWM_CNT_LO: s_axi_rdata[7:0] <= counter_one_value[7:0];
               `ARPWM_RLD_HI: s_axi_rdata[7:0] <= hi_byte(counter_one_reload);
               `ARPWM_RLD_LO: s_axi_rdata[7:0] <= counter_one_reload[7:0];
               `ARPWM_OEN: s_axi_rdata[7:0] <= pwm_output_enables;
               `ARPWM_BRK1: s_axi_rdata[7:0] <= break_one_control;
               `ARPWM_BRK2: s_axi_rdata[7:0] <= break_two_control;
               `ARPWM_BRKEN: s_axi_rdata[7:0] <= {6'h00, break_enables};
               `ARPWM_CAP_HI: s_axi_rdata[7:0] <= hi_byte(capture_result);
               `ARPWM_CAP_LO: s_axi_rdata[7:0] <= capture_result[7:0];
               `ARPWM_CNT2SEL: s_axi_rdata[7:0] <= {7'h00, counter_two_select};
               default: begin
                  s_axi_rresp <= `ARPWM_RESP_SLVERR;
                  for (i = 0; i < NCH; i = i + 1) begin
                     if (rd_a == ch_off(`ARPWM_CCS0, i)) begin
                        s_axi_rresp <= `ARPWM_RESP_OKAY;
                        s_axi_rdata[7:0] <= {4'h0,
                           (i == NCH - 1) ? one_shot_enable : 1'b0,
                           (i == NCH - 1) ? one_shot_trigger_edge : 1'b0,
                           channel_polarity[i], cmp_flag[i]};
                     end
                     if (rd_a == ch_off(`ARPWM_DUTY_HI0, i)) begin
                        s_axi_rresp <= `ARPWM_RESP_OKAY;
                        s_axi_rdata[7:0] <= hi_byte(channel_duty_value[i]);
                     end
                     if (rd_a == ch_off(`ARPWM_DUTY_LO0, i)) begin
                        s_axi_rresp <= `ARPWM_RESP_OKAY;
                        s_axi_rdata[7:0] <= channel_duty_value[i][7:0];
                     end
                  end
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Outputs and interrupt requests
   // ***************************************************************
   // Registered so the pins never glitch when break and enables change together.
   always @(posedge aclk) begin
      if (!aresetn) begin
         pwm_out <= 4'h0;
         pwm_pin_en <= 4'h0;
         overflow_irq <= 1'b0;
         capture_irq <= 1'b0;
         compare_irq <= 1'b0;
      end else begin
         pwm_pin_en <= oe4;
         for (i = 0; i < 4; i = i + 1) begin
            if ((i < 2 ? brk_lo : brk_hi) && oe4[i])
               pwm_out[i] <= break_one_control[i];
            else
               pwm_out[i] <= oe4[i] & (pwm_level[i] ^ channel_polarity[i]);
         end
         overflow_irq <= counter_one_overflow_flag && counter_one_overflow_irq_en;
         capture_irq <= capture_flag && capture_irq_enable;
         compare_irq <= (|cmp_flag) && compare_irq_enable;
      end
   end

endmodule

// ==== sim/arpwm_chk_sva.sv ====
// Purpose: Port checks of the autoreload PWM timer.
// Assumes: One clock; reset synchronous, active low.
// Notes:   Bound to arpwm_top below the module.
`timescale 1ns/10ps
`include "arpwm_defs.vh"
module arpwm_chk #(
   parameter NCH = 4
) (
   input wire        aclk,          // Clock.
   input wire        aresetn,       // Reset.
   input wire        s_axi_awvalid, // Bus.
   input wire        s_axi_awready, // Bus.
   input wire        s_axi_wvalid,  // Bus.
   input wire        s_axi_wready,  // Bus.
   input wire        s_axi_bvalid,  // Bus.
   input wire        s_axi_bready,  // Bus.
   input wire [7:0]  s_axi_araddr,  // Bus.
   input wire        s_axi_arvalid, // Bus.
   input wire        s_axi_arready, // Bus.
   input wire [31:0] s_axi_rdata,   // Bus.
   input wire        s_axi_rvalid,  // Bus.
   input wire        s_axi_rready,  // Bus.
   input wire        capture_event, // Capture.
   input wire        capture_irq,   // Request.
   input wire [3:0]  pwm_out,       // Pins.
   input wire [3:0]  pwm_pin_en     // Pin modes.
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // A capture in the window could legally set the flag again, so it is excluded.
   sequence s_cap_rd;
      s_rd_take ##0 (s_axi_araddr == `ARPWM_CAP_HI || s_axi_araddr == `ARPWM_CAP_LO)
         ##0 !capture_event ##1 !capture_event [*3];
   endsequence
   a_wr_answer: assert property (s_wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response late");
   a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read data late");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_pin_released: assert property ((pwm_out & ~pwm_pin_en) == 4'h0)
      else $error("released pin driven");
   a_cap_clear: assert property (s_cap_rd |=> !capture_irq)
      else $error("capture request not cleared");
   a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
      && pwm_pin_en == 4'h0 && !capture_irq) else $error("outputs busy after reset");
endmodule
bind arpwm_top arpwm_chk #(.NCH(NCH)) u_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .capture_event, .capture_irq, .pwm_out, .pwm_pin_en);

// ==== sim/arpwm_far.sv ====
// Purpose: Pins and comparators around the timer.
// Assumes: Ticks are one-cycle pulses on aclk.
// Notes:   Break two pin is pulled up, comparator two idles low.
`timescale 1ns/10ps
module arpwm_far (
   input  wire aclk,       // Clock.
   input  wire brk_lvl,    // Break one pin level.
   input  wire cmp_lvl,    // Comparator one level.
   output reg  lite_tick,  // Slow tick.
   output reg  fast_tick,  // Fast tick.
   output wire brk_one,    // Break one pin.
   output wire brk_two,    // Break two pin.
   output wire cmp_one,    // Comparator one.
   output wire cmp_two,    // Comparator two.
   output wire cap_pin     // Capture pin.
);
   reg [2:0] div = 3'h0;
   initial lite_tick = 1'b0;
   initial fast_tick = 1'b0;
   always @(posedge aclk) begin
      div <= div + 3'h1;
      lite_tick <= (div == 3'h7);
      fast_tick <= div[0];
   end
   assign brk_one = brk_lvl;
   assign brk_two = 1'b1;
   assign cmp_one = cmp_lvl;
   assign cmp_two = 1'b0;
   assign cap_pin = 1'b0;
endmodule

// ==== sim/autoreload_pwm_timer_control_test.sv ====
// Purpose: Register-level tests of the autoreload PWM timer.
// Assumes: AXI4-Lite master, 200 MHz clock.
// Notes:   Counter runs from the CPU clock for one full wrap from zero, then wraps from the reload value.
`timescale 1ns/10ps
`include "arpwm_defs.vh"
module autoreload_pwm_timer_control_test;
   reg         aclk = 1'b0;
   reg         aresetn = 1'b0;
   reg  [7:0]  awaddr = 8'h00;
   reg         awvalid = 1'b0;
   reg  [31:0] wdata = 32'h0;
   reg         wvalid = 1'b0;
   reg         bready = 1'b0;
   reg  [7:0]  araddr = 8'h00;
   reg         arvalid = 1'b0;
   reg         rready = 1'b0;
   reg         cap_ev = 1'b0;
   reg         brk_lvl = 1'b0;
   reg         cmp_lvl = 1'b0;
   reg  [31:0] got;
   reg  [1:0]  got_resp;
   reg         p0;
   wire        awready, wready, bvalid, arready, rvalid, lt, ft, b1, b2, c1, c2, cp;
   wire        osh, oirq, cirq, mirq;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [3:0]  pwm, pen;
   integer     fail_count = 0;
   integer     n_compared = 0;
   integer     cyc = 0;
   always #2.5 aclk = ~aclk;
   arpwm_far far (.aclk(aclk), .brk_lvl(brk_lvl), .cmp_lvl(cmp_lvl), .lite_tick(lt),
      .fast_tick(ft), .brk_one(b1), .brk_two(b2), .cmp_one(c1), .cmp_two(c2), .cap_pin(cp));
   arpwm_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .lite_tick(lt), .fast_tick(ft), .capture_event(cap_ev),
      .lite_timer_capture_input(cp), .break_one_input(b1), .break_two_input(b2),
      .comp_one_out(c1), .comp_two_out(c2), .pwm_out(pwm), .pwm_pin_en(pen),
      .one_shot_trigger(osh), .overflow_irq(oirq), .capture_irq(cirq), .compare_irq(mirq));
   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= {24'h0, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
         end while (!bvalid);
         got_resp = bresp;
         bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
         end while (!rvalid);
         got = rdata;
         got_resp = rresp;
         rready <= 1'b0;
      end
   endtask
   task rdc(input [7:0] a, input [31:0] exp);
      begin
         rd(a);
         check(got, exp);
      end
   endtask
   task wrap_up;
      begin
         $display("compared %0d, mismatches %0d", n_compared, fail_count);
         if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         wrap_up;
      end
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(`ARPWM_BRKEN, 32'h03);
      rdc(`ARPWM_TCSR, 32'h00);
      wr(`ARPWM_RLD_HI, 8'hff);
      rdc(`ARPWM_RLD_HI, 32'h0f);
      wr(`ARPWM_RLD_LO, 8'hf0);
      wr(`ARPWM_DUTY_HI0, 8'h0f);
      wr(`ARPWM_DUTY_LO0, 8'hf5);
      // A full wrap from zero needs 4096 ticks of the CPU clock.
      wr(`ARPWM_TCSR, 8'h13);
      repeat (4200) @(posedge aclk);
      wr(`ARPWM_TCSR, 8'h03);
      check(oirq, 1);
      check(mirq, 1);
      rd(`ARPWM_CNT_LO);
      rdc(`ARPWM_CNT_HI, 32'h0f);
      rdc(`ARPWM_TCSR, 32'h07);
      rdc(`ARPWM_TCSR, 32'h03);
      rdc(`ARPWM_CCS0, 32'h01);
      rdc(`ARPWM_CCS0, 32'h00);
      wr(`ARPWM_CCS0 + 8'h0c, 8'h0c);
      check(got_resp, `ARPWM_RESP_OKAY);
      rdc(`ARPWM_CCS0 + 8'h0c, 32'h0d);
      rdc(`ARPWM_CCS0 + 8'h0c, 32'h0c);
      wr(`ARPWM_TCSR, 8'h20);
      cap_ev <= 1'b1;
      @(posedge aclk);
      cap_ev <= 1'b0;
      rdc(`ARPWM_TCSR, 32'h60);
      check(cirq, 1);
      wr(`ARPWM_TCSR, 8'h20);
      rdc(`ARPWM_TCSR, 32'h60);
      rd(`ARPWM_CAP_LO);
      rdc(`ARPWM_TCSR, 32'h20);
      rdc(8'h7c, 32'h0);
      check(got_resp, `ARPWM_RESP_SLVERR);
      wr(`ARPWM_OEN, 8'h01);
      repeat (2) @(posedge aclk);
      check(pen, 4'h1);
      p0 = pwm[0];
      wr(`ARPWM_CCS0, 8'h02);
      repeat (2) @(posedge aclk);
      check(pwm[0], !p0);
      wr(`ARPWM_BRK1, 8'h50 | p0);
      brk_lvl <= 1'b1;
      repeat (3) @(posedge aclk);
      rdc(`ARPWM_BRK1, {24'h0, 8'h70 | p0});
      check(pwm[0], p0);
      wr(`ARPWM_BRKEN, 8'h00);
      repeat (2) @(posedge aclk);
      check(pwm[0], !p0);
      wr(`ARPWM_BRKEN, 8'h03);
      // The pin is still active in the first write's cycle, so the set wins once.
      wr(`ARPWM_BRK1, 8'h40 | p0);
      wr(`ARPWM_BRK1, 8'h40 | p0);
      repeat (2) @(posedge aclk);
      check(pwm[0], !p0);
      wr(`ARPWM_BRK2, 8'h51);
      repeat (3) @(posedge aclk);
      rdc(`ARPWM_BRK2, 32'h71);
      check(pwm[0], p0);
      wr(`ARPWM_BRK1, 8'hd0 | p0);
      brk_lvl <= 1'b0;
      cmp_lvl <= 1'b1;
      repeat (3) @(posedge aclk);
      rdc(`ARPWM_BRK1, {24'h0, 8'hf0 | p0});
      wrap_up;
   end
endmodule
